// *** rtl/pmc_macrocell.sv ***
// configurable output macrocell with wishbone configuration port
`timescale 1ns/10ps
module pmc_macrocell import pmc_pkg::*; #(
  parameter int ARRAY_IN = `PMC_ARRAY_IN
) (
  // system
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [5:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // and array and clocks
  input  wire logic [ARRAY_IN-1:0] array_i,
  input  wire logic                left_half_sync_clock_i,
  input  wire logic                right_half_sync_clock_i,
  // pin and feedback
  input  wire logic                pin_i,
  output logic                     pin_o,
  output logic                     pin_oe_n_o,
  output logic                     feedback_o
);

  localparam int TW = 2 * ARRAY_IN;

  typedef struct packed {
    pmc_cfg_type                          cfg;
    logic [`PMC_NUM_TERMS-1:0][TW-1:0]    term;
    logic                                 ff;
    logic                                 lclk;
    logic                                 rclk;
    logic                                 ptclk;
    logic                                 pin;
    logic                                 pin_oe_n;
    logic                                 fb;
    pmc_bus_type                          bus;
  } pmc_state_type;

  pmc_state_type state;
  pmc_state_type next_state;

  //------------------------------------------------------------
  // product terms
  //------------------------------------------------------------
  logic [TW-1:0]             literals;
  logic [`PMC_NUM_TERMS-1:0] pt;

  assign literals = {~array_i, array_i};

  genvar k;
  generate
    for (k = 0; k < `PMC_NUM_TERMS; k++) begin : g_term
      // connected literal must be true; open literal is ignored
      assign pt[k] = &(~state.term[k] | literals);
    end
  endgenerate

  //------------------------------------------------------------
  // sums and register inputs
  //------------------------------------------------------------
  logic [7:0] jmask;
  logic       sum_all;
  logic       in_a;
  logic       in_b;
  logic       clk_edge;
  logic       rst_term;
  logic       bypass;
  logic       bus_req;
  logic [3:0] tidx;

  assign rst_term = pt[`PMC_RST_TERM];
  assign bypass   = state.cfg.rtype > PMC_REG_SR;
  assign jmask    = 8'hff >> (3'h7 - state.cfg.split);
  // one gate for D/T, polarity applied before register and bypass path
  assign sum_all  = (|pt[`PMC_LOGIC_TERMS-1:0]) ^ state.cfg.inv;
  // J/S gets terms 0 to split, K/R the rest; invert hits both
  assign in_a     = (|(pt[7:0] & jmask)) ^ state.cfg.inv;
  assign in_b     = (|(pt[7:0] & ~jmask)) ^ state.cfg.inv;
  assign bus_req  = cyc_i & stb_i & ~state.bus.ack;
  assign tidx     = 4'(adr_i[5:2] - 4'h1);

  always_comb begin
    if (state.cfg.mode1) begin
      clk_edge = pt[`PMC_OECK_TERM] & ~state.ptclk;
    end else if (state.cfg.half) begin
      clk_edge = right_half_sync_clock_i & ~state.rclk;
    end else begin
      clk_edge = left_half_sync_clock_i & ~state.lclk;
    end
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_state.lclk  = left_half_sync_clock_i;
    next_state.rclk  = right_half_sync_clock_i;
    next_state.ptclk = pt[`PMC_OECK_TERM];

    // register, updates regardless of the driver state
    if (rst_term) begin
      next_state.ff = 1'b0;
    end else if (clk_edge && !bypass) begin
      case (state.cfg.rtype)
        PMC_REG_D:  next_state.ff = sum_all;
        PMC_REG_T:  next_state.ff = state.ff ^ sum_all;
        PMC_REG_JK: begin
          if (in_a && in_b) begin
            next_state.ff = ~state.ff;
          end else if (in_a) begin
            next_state.ff = 1'b1;
          end else if (in_b) begin
            next_state.ff = 1'b0;
          end
        end
        // set and reset together is undefined; set is taken
        PMC_REG_SR: begin
          if (in_a) begin
            next_state.ff = 1'b1;
          end else if (in_b) begin
            next_state.ff = 1'b0;
          end
        end
        default: next_state.ff = state.ff;
      endcase
    end

    // output select and driver enable
    case (state.cfg.osel)
      PMC_OUT_REG:  next_state.pin = next_state.ff;
      PMC_OUT_COMB: next_state.pin = sum_all;
      default:      next_state.pin = 1'b0;
    endcase
    if (state.cfg.osel < PMC_OUT_REG) begin
      next_state.pin_oe_n = 1'b1;
    end else if (state.cfg.mode1) begin
      next_state.pin_oe_n = 1'b0;
    end else begin
      next_state.pin_oe_n = ~pt[`PMC_OECK_TERM];
    end

    // feedback select
    case (state.cfg.fsel)
      PMC_FB_PIN: next_state.fb = pin_i;
      PMC_FB_REG: next_state.fb = next_state.ff;
      PMC_FB_SUM: next_state.fb = sum_all;
      default:    next_state.fb = 1'b0;
    endcase

    // wishbone: ack one cycle after the request, then drop
    next_state.bus.ack = bus_req;
    next_state.bus.dat = 32'h0;
    if (bus_req) begin
      if (adr_i == `PMC_ADR_CFG) begin
        next_state.bus.dat = 32'(state.cfg);
        if (we_i && sel_i[0]) begin
          next_state.cfg[7:0] = dat_i[7:0];
        end
        if (we_i && sel_i[1]) begin
          next_state.cfg[`PMC_CFG_W-1:8] = dat_i[`PMC_CFG_W-1:8];
        end
      end else if (adr_i == `PMC_ADR_STAT) begin
        next_state.bus.dat = {18'h0, pt, state.fb, ~state.pin_oe_n, state.pin, state.ff};
      end else if (adr_i[1:0] == 2'h0 && adr_i >= `PMC_ADR_TERM0 && adr_i < `PMC_ADR_STAT) begin
        next_state.bus.dat = 32'(state.term[tidx]);
        if (we_i && sel_i[0]) begin
          next_state.term[tidx][7:0] = dat_i[7:0];
        end
        if (we_i && sel_i[1]) begin
          next_state.term[tidx][TW-1:8] = dat_i[TW-1:8];
        end
      end
    end
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= '0;
      state.ff       <= 1'b0;
      state.cfg      <= `PMC_CFG_RESET;
      state.term     <= {`PMC_NUM_TERMS{`PMC_TERM_RESET}};
      state.pin_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign dat_o      = state.bus.dat;
  assign ack_o      = state.bus.ack;
  assign pin_o      = state.pin;
  assign pin_oe_n_o = state.pin_oe_n;
  assign feedback_o = state.fb;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  a_reset_term_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rst_term |=> !state.ff)
    else $error("reset term did not clear the register");

  a_mode1_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.mode1 && state.cfg.osel >= PMC_OUT_REG) |=> !pin_oe_n_o)
    else $error("mode 1 driver not enabled");

  a_mode0_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (!state.cfg.mode1 && state.cfg.osel >= PMC_OUT_REG) |=> pin_oe_n_o == !$past(pt[`PMC_OECK_TERM]))
    else $error("mode 0 driver does not follow enable term");

  a_dtype_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_D && clk_edge && !rst_term) |=> state.ff == $past(sum_all))
    else $error("d register did not capture the sum");

  a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_T && clk_edge && !rst_term && sum_all) |=> state.ff != $past(state.ff))
    else $error("t register did not toggle");

  a_hold_no_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clk_edge && !rst_term) |=> $stable(state.ff))
    else $error("register changed without a clock edge");

  a_pin_input: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.osel < PMC_OUT_REG && state.cfg.fsel == PMC_FB_PIN) |=> pin_oe_n_o && feedback_o == $past(pin_i))
    else $error("dedicated input not honoured");

  a_bypass_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.osel == PMC_OUT_COMB) |=> pin_o == $past(sum_all))
    else $error("combinatorial output mismatch");

  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("wishbone ack not a single cycle");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");

  a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && we_i && adr_i == `PMC_ADR_CFG && sel_i[1:0] == 2'h3)
    |=> 32'(state.cfg) == 32'($past(dat_i[`PMC_CFG_W-1:0])))
    else $error("configuration write not stored");

  //------------------------------------------------------------
  // register type assertions
  //------------------------------------------------------------
  a_jk_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_JK && clk_edge && !rst_term && in_a && in_b) |=> state.ff != $past(state.ff))
    else $error("jk register did not toggle");

  a_jk_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_JK && clk_edge && !rst_term && in_a && !in_b) |=> state.ff)
    else $error("jk register did not set");

  a_jk_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_JK && clk_edge && !rst_term && !in_a && in_b) |=> !state.ff)
    else $error("jk register did not clear");

  a_sr_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_SR && clk_edge && !rst_term && in_a) |=> state.ff)
    else $error("sr register did not set");

  a_sr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_SR && clk_edge && !rst_term && !in_a && in_b) |=> !state.ff)
    else $error("sr register did not clear");

  a_toggle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.rtype == PMC_REG_T && clk_edge && !rst_term && !sum_all) |=> $stable(state.ff))
    else $error("t register changed with input low");

  a_bypass_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (bypass && !rst_term) |=> $stable(state.ff))
    else $error("bypassed register changed");

  //------------------------------------------------------------
  // clock source and product term assertions
  //------------------------------------------------------------
  a_left_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (!state.cfg.mode1 && !state.cfg.half && state.cfg.rtype == PMC_REG_D && !rst_term
     && left_half_sync_clock_i && !state.lclk) |=> state.ff == $past(sum_all))
    else $error("left half clock edge not captured");

  a_right_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (!state.cfg.mode1 && state.cfg.half && state.cfg.rtype == PMC_REG_D && !rst_term
     && right_half_sync_clock_i && !state.rclk) |=> state.ff == $past(sum_all))
    else $error("right half clock edge not captured");

  a_term_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.mode1 && state.cfg.rtype == PMC_REG_D && !rst_term
     && pt[`PMC_OECK_TERM] && !state.ptclk) |=> state.ff == $past(sum_all))
    else $error("clock term edge not captured");

  a_term_open: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.term[`PMC_OECK_TERM] == '0) |-> pt[`PMC_OECK_TERM])
    else $error("open product term not true");

  a_term_both: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.term[`PMC_RST_TERM][0] && state.term[`PMC_RST_TERM][ARRAY_IN]) |-> !rst_term)
    else $error("term with both literals not false");

  //------------------------------------------------------------
  // output and feedback assertions
  //------------------------------------------------------------
  a_reg_output: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.osel == PMC_OUT_REG) |=> pin_o == state.ff)
    else $error("registered output does not show the register");

  a_out_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.osel < PMC_OUT_REG) |=> pin_oe_n_o && !pin_o)
    else $error("no output selected but pin driven");

  a_fb_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.fsel == PMC_FB_REG) |=> feedback_o == state.ff)
    else $error("register feedback mismatch");

  a_fb_sum: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.fsel == PMC_FB_SUM) |=> feedback_o == $past(sum_all))
    else $error("sum feedback mismatch");

  a_fb_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.cfg.fsel == PMC_FB_NONE) |=> !feedback_o)
    else $error("feedback present with none selected");

endmodule // pmc_macrocell

// *** include/pmc_consts.svh ***
// constants of the configurable output macrocell
//------------------------------------------------------------
// Behaviour
// - combinatorial or registered output, polarity, feedback
// - tri-state or always-on mode chosen per cell
// - mode 0: enable term drives, else float
// - mode 0: clocked by its half clock
// - mode 0: register updates while pin floats
// - mode 1: driver enabled whenever an output is selected
// - mode 1: clocked by enable/clock term
// - mode 1: either edge via term polarity
// - invert bit inverts register inputs, both
// - register type T, D, JK, SR or bypass
// - reset term clears register regardless of clock
// - register cleared at power up
// - D/T: eight terms ORed into input
// - JK/SR: eight terms split between two ORs
// - output select: register, sum, or none
// - feedback select: register, sum, pin, or none
// - summed terms may feed back to array
// - no output plus pin feedback is input
// - erased: combinatorial active-low, pin feedback
// - erased configuration bits read as one
// - ten terms: eight logic, reset, enable/clock
// - term: both literals false, none true
// - half clocks capture on rising edge
//------------------------------------------------------------
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_ARRAY_IN   8
`define PMC_NUM_TERMS  10
`define PMC_LOGIC_TERMS 8
`define PMC_RST_TERM   8
`define PMC_OECK_TERM  9
`define PMC_CFG_W      13

// register byte offsets
`define PMC_ADR_CFG    6'h00
`define PMC_ADR_TERM0  6'h04
`define PMC_ADR_STAT   6'h2c

// configuration field positions
`define PMC_F_MODE     0
`define PMC_F_HALF     1
`define PMC_F_TYPE_LO  2
`define PMC_F_INV      5
`define PMC_F_OSEL_LO  6
`define PMC_F_FSEL_LO  8
`define PMC_F_SPLIT_LO 10

// erased state: every bit connected
`define PMC_CFG_RESET  13'h1fff
`define PMC_TERM_RESET 16'hffff

`endif

// *** include/pmc_pkg.sv ***
// types of the configurable output macrocell
package pmc_pkg;
`include "pmc_consts.svh"

  typedef enum logic [2:0] {
    PMC_REG_D  = 3'h0,
    PMC_REG_T  = 3'h1,
    PMC_REG_JK = 3'h2,
    PMC_REG_SR = 3'h3
  } pmc_reg_type;

  typedef enum logic [1:0] {
    PMC_OUT_REG  = 2'h2,
    PMC_OUT_COMB = 2'h3
  } pmc_osel_type;

  typedef enum logic [1:0] {
    PMC_FB_NONE = 2'h0,
    PMC_FB_SUM  = 2'h1,
    PMC_FB_REG  = 2'h2,
    PMC_FB_PIN  = 2'h3
  } pmc_fsel_type;

  typedef struct packed {
    logic [2:0] split;
    logic [1:0] fsel;
    logic [1:0] osel;
    logic       inv;
    logic [2:0] rtype;
    logic       half;
    logic       mode1;
  } pmc_cfg_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pmc_bus_type;
endpackage

// *** tb/pmc_board_model.sv ***
// board logic on the cell pin: weak pull-up, optional board driver
`timescale 1ns/10ps
module pmc_board_model (
  // from the cell
  input  wire logic pin_o,
  input  wire logic pin_oe_n_o,
  // board side stimulus
  input  wire logic drive_en_i,
  input  wire logic drive_val_i,
  // resolved pin level
  output logic      pin_i
);
  // a released pin with nobody driving settles at the pull-up level
  always_comb begin
    if (!pin_oe_n_o) begin
      pin_i = pin_o;
    end else if (drive_en_i) begin
      pin_i = drive_val_i;
    end else begin
      pin_i = 1'b1;
    end
  end
endmodule // pmc_board_model

// *** tb/tb_pld_macrocell_config.sv ***
// self-checking testbench of the configurable output macrocell
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_pld_macrocell_config import pmc_pkg::*;;
  logic        clk_i, rst_i, cyc, stb, we, ack_o, lclk, rclk;
  logic        pin_i, pin_o, oe_n, fb, bd_en, bd_val;
  logic [5:0]  adr;
  logic [31:0] wdat, dat_o, rd;
  logic [7:0]  arr;
  int          err_count, n_checks;

  pmc_macrocell i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .array_i(arr), .left_half_sync_clock_i(lclk),
    .right_half_sync_clock_i(rclk), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .feedback_o(fb));
  pmc_board_model i_board (.pin_o(pin_o), .pin_oe_n_o(oe_n), .drive_en_i(bd_en), .drive_val_i(bd_val),
    .pin_i(pin_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  //------------------------------------------------------------
  // bus and helper tasks
  //------------------------------------------------------------
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("mismatch bus ack expected 1 seen none");
    end
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic set_arr(input logic [7:0] v);
    arr <= v;
    cyc_n(4);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_erased();
    wb(1'b0, 6'h00, 32'h0);
    `CHK("cfg", 32'h00001fff, rd)
    wb(1'b0, 6'h28, 32'h0);
    `CHK("term9", 32'h0000ffff, rd)
    `CHK("oe_n", 1'b0, oe_n)
    `CHK("pin", 1'b1, pin_o)
    `CHK("fb", 1'b1, fb)
    wb(1'b0, 6'h2c, 32'h0);
    `CHK("ff", 1'b0, rd[0])
    wb(1'b0, 6'h30, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test erased done");
  endtask

  task automatic t_comb();
    wb(1'b1, 6'h00, 32'h1d1);
    wb(1'b1, 6'h04, 32'h0001);
    wb(1'b1, 6'h20, 32'h0002);
    set_arr(8'h00);
    `CHK("pin", 1'b0, pin_o)
    set_arr(8'h01);
    `CHK("pin", 1'b1, pin_o)
    `CHK("fb sum", 1'b1, fb)
    set_arr(8'h02);
    `CHK("pin or", 1'b1, pin_o)
    wb(1'b1, 6'h00, 32'h1f1);
    cyc_n(3);
    `CHK("pin inv", 1'b0, pin_o)
    $display("test comb done");
  endtask

  task automatic t_dreg();
    wb(1'b1, 6'h00, 32'h280);
    wb(1'b1, 6'h28, 32'h0010);
    set_arr(8'h01);
    rclk <= 1'b1;
    cyc_n(4);
    wb(1'b0, 6'h2c, 32'h0);
    `CHK("ff other half", 1'b0, rd[0])
    lclk <= 1'b1;
    cyc_n(4);
    `CHK("oe_n", 1'b1, oe_n)
    wb(1'b0, 6'h2c, 32'h0);
    `CHK("ff", 1'b1, rd[0])
    set_arr(8'h11);
    `CHK("oe_n", 1'b0, oe_n)
    `CHK("pin", 1'b1, pin_o)
    wb(1'b1, 6'h24, 32'h0004);
    set_arr(8'h15);
    `CHK("pin cleared", 1'b0, pin_o)
    wb(1'b1, 6'h24, 32'hffff);
    lclk <= 1'b0;
    rclk <= 1'b0;
    $display("test dreg done");
  endtask

  task automatic t_tmode1();
    wb(1'b1, 6'h00, 32'h285);
    wb(1'b1, 6'h28, 32'h0008);
    set_arr(8'h01);
    `CHK("oe_n", 1'b0, oe_n)
    set_arr(8'h09);
    `CHK("pin", 1'b1, pin_o)
    set_arr(8'h01);
    `CHK("pin hold", 1'b1, pin_o)
    set_arr(8'h09);
    `CHK("pin toggle", 1'b0, pin_o)
    wb(1'b1, 6'h28, 32'h0800);
    set_arr(8'h01);
    `CHK("pin fall", 1'b1, pin_o)
    $display("test tmode1 done");
  endtask

  task automatic t_input();
    wb(1'b1, 6'h00, 32'h311);
    bd_en <= 1'b1;
    bd_val <= 1'b0;
    cyc_n(4);
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("fb", 1'b0, fb)
    bd_val <= 1'b1;
    cyc_n(4);
    `CHK("fb", 1'b1, fb)
    $display("test input done");
  endtask

  task automatic t_jksr();
    bd_en <= 1'b0;
    wb(1'b1, 6'h00, 32'h28a);
    wb(1'b1, 6'h28, 32'h0000);
    set_arr(8'h02);
    `CHK("oe_n open term", 1'b0, oe_n)
    rclk <= 1'b1;
    cyc_n(4);
    `CHK("jk clear", 1'b0, pin_o)
    rclk <= 1'b0;
    set_arr(8'h03);
    rclk <= 1'b1;
    cyc_n(4);
    `CHK("jk toggle", 1'b1, pin_o)
    rclk <= 1'b0;
    wb(1'b1, 6'h00, 32'h28e);
    set_arr(8'h02);
    rclk <= 1'b1;
    cyc_n(4);
    `CHK("sr reset", 1'b0, pin_o)
    rclk <= 1'b0;
    set_arr(8'h03);
    rclk <= 1'b1;
    cyc_n(4);
    `CHK("sr set", 1'b1, pin_o)
    $display("test jksr done");
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    rst_i = 1'b1;
    {cyc, stb, we, lclk, rclk, bd_en, bd_val} = '0;
    adr = '0;
    wdat = '0;
    arr = '0;
    cyc_n(2);
    rst_i <= 1'b0;
    cyc_n(2);
    t_erased();
    t_comb();
    t_dreg();
    t_tmode1();
    t_input();
    t_jksr();
    finish_test();
  end

  initial begin
    #100us;
    err_count++;
    finish_test();
  end
endmodule // tb_pld_macrocell_config
